// File: design/adc_pkg.sv
// Constants, register offsets and field positions for the converter control.
// Assumes a 16-bit intermodule slave port with byte offsets within the module.
// Functional notes
// - Stop bit high gates the conversion clock and powers down analog circuits.
// - Writing stop high aborts any running conversion sequence.
// - Stop bit resets to one; software clears it to enable conversions.
// - Freeze field: 00 ignore, 01 reserved, 10 finish then halt, 11 halt now.
// - Privileged select bit resets to one, is stored, changes no permissions.
// - Port data read returns the eight pin levels in bits 7..0.
// - Digital pin reads never block analog conversion of that pin.
// - Clock and sample control writes take effect immediately.
// - Resolution bit picks 8 or 10 bits; results aligned to match.
// - Sample time codes give 2, 4, 8 or 16 conversion clocks.
// - Conversion clock divides system clock by prescale plus one, then two.
// - Prescale resets to a total divisor of eight.
// - Channel/mode register always accessible; every write starts a sequence unless stop is set.
// - Write during a sequence aborts it and clears done flags.
// - Sequencer drives mux and array, accumulates decisions, stores results.
// - Eight result registers plus port, control and status registers.
// - Slave only; every access is terminated with an acknowledge.
// - Scan bit selects single or continuous sequences.
// - Length bit selects four or eight conversions per sequence.
// - Block select converts a block of channels in order, else one channel.
// - Sequence-done set on completion, zero while incomplete; in scan mode it stays set until the next channel/mode write.
package adc_pkg;
  localparam int unsigned ADC_AW = 6;
  localparam logic [5:0] ADC_OFS_CFG = 6'h00;
  localparam logic [5:0] ADC_OFS_PORT = 6'h06;
  localparam logic [5:0] ADC_OFS_CLK = 6'h0A;
  localparam logic [5:0] ADC_OFS_CHN = 6'h0C;
  localparam logic [5:0] ADC_OFS_STAT = 6'h0E;
  localparam logic [5:0] ADC_OFS_RES = 6'h10;
  localparam logic [5:0] ADC_RES_MASK = 6'h30;
  // module_config fields
  localparam int unsigned ADC_CFG_STOP = 15;
  localparam int unsigned ADC_CFG_FREEZE = 13;
  localparam int unsigned ADC_CFG_PRIV = 7;
  // clock_sample_control fields
  localparam int unsigned ADC_CLK_RESSEL = 7;
  localparam int unsigned ADC_CLK_SAMP = 5;
  localparam int unsigned ADC_CLK_DIV = 0;
  // channel_mode_control fields
  localparam int unsigned ADC_CHN_SCAN = 6;
  localparam int unsigned ADC_CHN_BLOCK = 5;
  localparam int unsigned ADC_CHN_LEN8 = 4;
  // converter_status fields
  localparam int unsigned ADC_STAT_DONE = 15;
  localparam int unsigned ADC_STAT_COUNT = 8;
  // Reset values
  localparam logic ADC_RST_STOP = 1'b1;
  localparam logic ADC_RST_PRIV = 1'b1;
  localparam logic [1:0] ADC_RST_FREEZE = 2'h0;
  localparam logic [4:0] ADC_RST_DIV = 5'h03;
  localparam logic [1:0] ADC_RST_SAMP = 2'h0;
  localparam logic ADC_RST_RESSEL = 1'b0;
  localparam logic [6:0] ADC_RST_CHN = 7'h00;
  // Freeze responses
  localparam logic [1:0] ADC_FREEZE_FINISH = 2'h2;
  localparam logic [1:0] ADC_FREEZE_NOW = 2'h3;
  // Sample time base in conversion clocks
  localparam logic [4:0] ADC_SAMP_BASE = 5'h02;
  typedef enum logic [1:0] {ADC_ST_IDLE, ADC_ST_SAMPLE, ADC_ST_CONV} adc_state_t;
endpackage : adc_pkg

// File: design/adc_prescaler.sv
// Conversion clock enable generator: modulo counter then divide by two.
// Assumes one system clock; the result is a one-cycle enable pulse.
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic hold,
  input wire logic [4:0] clock_divider_select,
  // Enable out
  output logic tick
);
  logic [4:0] cnt_q;
  logic half_q;
  logic wrap;
  assign wrap = (cnt_q >= clock_divider_select);
  assign tick = wrap & half_q & ~hold;
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_q <= 5'h00;
      half_q <= 1'b0;
    end
    else if (hold)
    begin
      cnt_q <= 5'h00;
      half_q <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_q <= 5'h00;
      half_q <= ~half_q;
    end
    else
    begin
      cnt_q <= cnt_q + 5'h01;
    end
  end
endmodule : adc_prescaler
`default_nettype wire

// File: design/adc_sar.sv
// Successive-approximation register: one decision per conversion clock.
// Assumes comparator high means the sampled input is above the trial code.
`timescale 1ns/1ps
`default_nettype none
module adc_sar #(
  parameter int unsigned W = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic res_sel,
  input wire logic cmp_high,
  // Outputs
  output logic [W-1:0] trial_q,
  output logic done_q,
  output logic [W-1:0] result_q
);
  logic [W-1:0] bit_q;
  logic [W-1:0] kept;
  logic [W-1:0] lsb;
  assign kept = cmp_high ? trial_q : (trial_q & ~bit_q);
  assign lsb = res_sel ? W'(1) : W'(4);
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_q <= '0;
      trial_q <= '0;
      done_q <= 1'b0;
      result_q <= '0;
    end
    else if (abort)
    begin
      bit_q <= '0;
      trial_q <= '0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      bit_q <= W'(1) << (W - 1);
      trial_q <= W'(1) << (W - 1);
      done_q <= 1'b0;
    end
    else if (tick && bit_q != '0)
    begin
      bit_q <= (bit_q == lsb) ? '0 : (bit_q >> 1);
      trial_q <= (bit_q == lsb) ? kept : (kept | (bit_q >> 1));
      done_q <= (bit_q == lsb);
      result_q <= res_sel ? kept : (kept >> 2);
    end
    else
    begin
      done_q <= 1'b0;
    end
  end
endmodule : adc_sar
`default_nettype wire

// File: design/adc_ctrl.sv
// Converter digital control: registers, prescaler, sequencer and results.
// Assumes single-cycle bus requests; acknowledge follows one cycle later.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl #(
  parameter int unsigned RES_W = 10,
  parameter int unsigned NRES = 8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Intermodule bus slave
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [adc_pkg::ADC_AW-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata_q,
  output logic bus_ack_q,
  // Debug
  input wire logic debug_halt_request,
  // Pins and analog front end
  input wire logic [7:0] port_pin_levels,
  input wire logic cmp_high,
  output logic [3:0] mux_sel_q,
  output logic sample_q,
  output logic [RES_W-1:0] trial_code_q,
  output logic analog_pd_q
);
  import adc_pkg::*;

  function automatic logic [2:0] last_idx(input logic s8);
    last_idx = s8 ? 3'h7 : 3'h3;
  endfunction : last_idx

  // Configuration registers
  logic stop_q;
  logic [1:0] freeze_response_q;
  logic priv_q;
  logic resolution_select_q;
  logic [1:0] sample_time_select_q;
  logic [4:0] clock_divider_select_q;
  logic [6:0] chn_q;
  // Sequencer state
  adc_state_t st_q;
  adc_state_t st_d;
  logic [2:0] idx_q;
  logic [4:0] samp_cnt_q;
  logic sequence_done_flag_q;
  logic [NRES-1:0] conversion_done_flags_q;
  logic [2:0] cctr_q;
  logic [RES_W-1:0] res_q [NRES];

  // Bus decode
  logic wr;
  logic w_cfg;
  logic w_clk;
  logic w_chn;
  logic stop_set;
  logic abort;
  logic start_seq;
  assign wr = bus_req & bus_wr;
  assign w_cfg = wr & (bus_addr == ADC_OFS_CFG);
  assign w_clk = wr & (bus_addr == ADC_OFS_CLK);
  assign w_chn = wr & (bus_addr == ADC_OFS_CHN);
  assign stop_set = w_cfg & bus_wdata[ADC_CFG_STOP];
  assign abort = stop_set | stop_q | w_chn;
  assign start_seq = w_chn & ~stop_q & ~stop_set;

  // Mode fields
  logic scan;
  logic blk;
  logic s8;
  logic [3:0] chan_field;
  assign scan = chn_q[ADC_CHN_SCAN];
  assign blk = chn_q[ADC_CHN_BLOCK];
  assign s8 = chn_q[ADC_CHN_LEN8];
  assign chan_field = chn_q[3:0];

  // Freeze and clock
  logic hold;
  logic tick;
  logic ctick;
  logic halt_now;
  logic halt_fin;
  assign halt_now = freeze_response_q == ADC_FREEZE_NOW;
  assign halt_fin = (freeze_response_q == ADC_FREEZE_FINISH) & (st_q == ADC_ST_SAMPLE);
  assign hold = debug_halt_request & (halt_now | halt_fin);
  assign ctick = tick & ~hold;

  adc_prescaler u_presc (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .hold(stop_q),
    .clock_divider_select(clock_divider_select_q),
    .tick(tick)
  );

  // Sample length and channel
  logic [4:0] samp_len;
  logic samp_last;
  logic samp_end;
  logic samp_show;
  logic [3:0] chan_d;
  assign samp_len = ADC_SAMP_BASE << sample_time_select_q;
  assign samp_last = (samp_cnt_q >= samp_len - 5'h01);
  assign samp_end = ctick & samp_last;
  assign samp_show = (st_q == ADC_ST_SAMPLE) & ~abort;
  assign chan_d = !blk ? chan_field :
                  s8 ? {chan_field[3], idx_q} :
                  {chan_field[3:2], idx_q[1:0]};

  // Successive approximation
  logic sar_done;
  logic [RES_W-1:0] sar_result;
  logic [RES_W-1:0] sar_trial;
  adc_sar #(.W(RES_W)) u_sar (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(samp_end & (st_q == ADC_ST_SAMPLE)),
    .abort(abort),
    .tick(ctick),
    .res_sel(resolution_select_q),
    .cmp_high(cmp_high),
    .trial_q(sar_trial),
    .done_q(sar_done),
    .result_q(sar_result)
  );

  logic conv_end;
  logic seq_end;
  assign conv_end = (st_q == ADC_ST_CONV) & sar_done;
  assign seq_end = conv_end & (idx_q == last_idx(s8));

  // Next state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ADC_ST_IDLE:
        st_d = ADC_ST_IDLE;
      ADC_ST_SAMPLE:
        if (samp_end)
        begin
          st_d = ADC_ST_CONV;
        end
      ADC_ST_CONV:
        if (seq_end && !scan)
        begin
          st_d = ADC_ST_IDLE;
        end
        else if (conv_end)
        begin
          st_d = ADC_ST_SAMPLE;
        end
      default:
        st_d = ADC_ST_IDLE;
    endcase
    if (abort)
    begin
      st_d = ADC_ST_IDLE;
    end
    if (start_seq)
    begin
      st_d = ADC_ST_SAMPLE;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      stop_q <= ADC_RST_STOP;
      freeze_response_q <= ADC_RST_FREEZE;
      priv_q <= ADC_RST_PRIV;
    end
    else if (w_cfg)
    begin
      stop_q <= bus_wdata[ADC_CFG_STOP];
      freeze_response_q <= bus_wdata[ADC_CFG_FREEZE +: 2];
      priv_q <= bus_wdata[ADC_CFG_PRIV];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      clock_divider_select_q <= ADC_RST_DIV;
      sample_time_select_q <= ADC_RST_SAMP;
      resolution_select_q <= ADC_RST_RESSEL;
    end
    else if (w_clk)
    begin
      clock_divider_select_q <= bus_wdata[ADC_CLK_DIV +: 5];
      sample_time_select_q <= bus_wdata[ADC_CLK_SAMP +: 2];
      resolution_select_q <= bus_wdata[ADC_CLK_RESSEL];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      chn_q <= ADC_RST_CHN;
    end
    else if (w_chn)
    begin
      chn_q <= bus_wdata[6:0];
    end
  end

  // Sequencer
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= ADC_ST_IDLE;
      idx_q <= 3'h0;
      samp_cnt_q <= 5'h00;
    end
    else
    begin
      st_q <= st_d;
      if (st_d != ADC_ST_SAMPLE || st_q != ADC_ST_SAMPLE || start_seq)
      begin
        samp_cnt_q <= 5'h00;
      end
      else if (ctick)
      begin
        samp_cnt_q <= samp_cnt_q + 5'h01;
      end
      if (start_seq || abort || seq_end)
      begin
        idx_q <= 3'h0;
      end
      else if (conv_end)
      begin
        idx_q <= idx_q + 3'h1;
      end
    end
  end

  // Flags and counter
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sequence_done_flag_q <= 1'b0;
      conversion_done_flags_q <= '0;
      cctr_q <= 3'h0;
    end
    else if (w_chn)
    begin
      sequence_done_flag_q <= 1'b0;
      conversion_done_flags_q <= '0;
      cctr_q <= 3'h0;
    end
    else if (conv_end)
    begin
      conversion_done_flags_q[idx_q] <= 1'b1;
      cctr_q <= idx_q + 3'h1;
      if (seq_end)
      begin
        sequence_done_flag_q <= 1'b1;
      end
    end
  end

  // Result registers
  genvar gi;
  generate
    for (gi = 0; gi < NRES; gi++)
    begin : g_res
      always_ff @(posedge clk_sys or negedge nrst)
      begin
        if (!nrst)
        begin
          res_q[gi] <= '0;
        end
        else if (conv_end && idx_q == 3'(gi))
        begin
          res_q[gi] <= sar_result;
        end
      end
    end
  endgenerate

  // Analog side outputs
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      mux_sel_q <= 4'h0;
      sample_q <= 1'b0;
      trial_code_q <= '0;
      analog_pd_q <= ADC_RST_STOP;
    end
    else
    begin
      mux_sel_q <= chan_d;
      sample_q <= samp_show;
      trial_code_q <= sar_trial;
      analog_pd_q <= stop_q;
    end
  end

  // Read mux
  logic [15:0] rd_cfg;
  logic [15:0] rd_clk;
  logic [15:0] rd_stat;
  logic [15:0] rd_mux;
  logic [2:0] rsel;
  assign rd_cfg = {stop_q, freeze_response_q, 5'h00, priv_q, 7'h00};
  assign rd_clk = {8'h00, resolution_select_q, sample_time_select_q, clock_divider_select_q};
  assign rd_stat = {sequence_done_flag_q, 4'h0, cctr_q, conversion_done_flags_q};
  assign rsel = bus_addr[3:1];
  assign rd_mux = ((bus_addr & ADC_RES_MASK) == ADC_OFS_RES) ?
                  16'(res_q[rsel]) :
                  (bus_addr == ADC_OFS_CFG) ? rd_cfg :
                  (bus_addr == ADC_OFS_PORT) ? {8'h00, port_pin_levels} :
                  (bus_addr == ADC_OFS_CLK) ? rd_clk :
                  (bus_addr == ADC_OFS_CHN) ? {9'h000, chn_q} :
                  (bus_addr == ADC_OFS_STAT) ? rd_stat :
                  16'h0000;

  // Bus termination
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_ack_q <= 1'b0;
      bus_rdata_q <= 16'h0000;
    end
    else
    begin
      bus_ack_q <= bus_req;
      bus_rdata_q <= (bus_req && !bus_wr) ? rd_mux : 16'h0000;
    end
  end
endmodule : adc_ctrl
`default_nettype wire

// File: tb/adc_ctrl_sva.sv
// Checker for the converter control bus and sequencer outputs.
// Sees only the top ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_sva #(
  parameter int unsigned RES_W = 10
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Bus
  input wire logic bus_req,
  input wire logic bus_wr,
  input wire logic [adc_pkg::ADC_AW-1:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata_q,
  input wire logic bus_ack_q,
  // Debug, pins, analog
  input wire logic debug_halt_request,
  input wire logic [7:0] port_pin_levels,
  input wire logic cmp_high,
  input wire logic [3:0] mux_sel_q,
  input wire logic sample_q,
  input wire logic [RES_W-1:0] trial_code_q,
  input wire logic analog_pd_q
);
  import adc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic cfg_wr;
  logic [1:0] freeze_q;
  assign cfg_wr = bus_req && bus_wr && (bus_addr == ADC_OFS_CFG);
  // Shadow of the freeze field
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      freeze_q <= ADC_RST_FREEZE;
    else if (cfg_wr)
      freeze_q <= bus_wdata[14:13];
  chk_ack_after_req: assert property (bus_req |=> bus_ack_q)
    else $error("no ack after request");
  chk_ack_only_req: assert property (!bus_req |=> !bus_ack_q)
    else $error("ack without request");
  chk_rdata_idle: assert property (!bus_ack_q |-> bus_rdata_q == 16'h0000)
    else $error("read data outside ack");
  chk_port_read: assert property (bus_req && !bus_wr && bus_addr == ADC_OFS_PORT
    |=> bus_rdata_q == {8'h00, $past(port_pin_levels)}) else $error("port read wrong");
  chk_pd_follows_stop: assert property (cfg_wr |-> ##2 analog_pd_q == $past(bus_wdata[15], 2))
    else $error("power down not following stop");
  chk_stop_quiet: assert property (analog_pd_q && $past(analog_pd_q) |-> !sample_q)
    else $error("sampling while stopped");
  chk_mux_hold: assert property (sample_q && $past(sample_q) |-> $stable(mux_sel_q))
    else $error("mux moved during sample");
  chk_freeze_now: assert property ((debug_halt_request && freeze_q == ADC_FREEZE_NOW)[*3]
    |-> $stable(trial_code_q) && $stable(sample_q)) else $error("sequencer moved in freeze");
  cov_stop_clear: cover property (cfg_wr && !bus_wdata[15]);
  cov_freeze: cover property (debug_halt_request && freeze_q == ADC_FREEZE_NOW);
  cov_sample_end: cover property ($fell(sample_q));
endmodule : adc_ctrl_sva
`default_nettype wire

// File: tb/adc_afe_model.sv
// Analog front end stand-in: fixed level per channel and a comparator.
// Comparator output toggles as junk while the front end is powered down.
`timescale 1ns/1ps
`default_nettype none
module adc_afe_model (
  // Clock
  input wire logic clk_sys,
  // Front end controls
  input wire logic [3:0] mux_sel_q,
  input wire logic [9:0] trial_code_q,
  input wire logic analog_pd_q,
  // Comparator
  output logic cmp_high
);
  logic junk_q = 1'b0;
  logic [9:0] level;
  assign level = 10'h011 + 10'(mux_sel_q) * 10'h07B;
  always @(posedge clk_sys)
    junk_q <= ~junk_q;
  assign cmp_high = analog_pd_q ? junk_q : (level >= trial_code_q);
endmodule : adc_afe_model
`default_nettype wire

// File: tb/test_adc_ctrl.sv
// Self-checking bench for the converter control block.
// Bus driven on falling edges; the front end model answers the comparator.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
  $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module test_adc_ctrl;
  import adc_pkg::*;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic bus_req = 1'b0;
  logic bus_wr = 1'b0;
  logic [ADC_AW-1:0] bus_addr = '0;
  logic [15:0] bus_wdata = '0;
  logic [15:0] bus_rdata_q;
  logic bus_ack_q;
  logic debug_halt_request = 1'b0;
  logic [7:0] port_pin_levels = 8'h00;
  logic cmp_high;
  logic [3:0] mux_sel_q;
  logic sample_q;
  logic [9:0] trial_code_q;
  logic analog_pd_q;
  logic [15:0] rd;
  int n_errors = 0;
  int checked = 0;
  adc_ctrl i_adc_ctrl (.clk_sys(clk_sys), .nrst(nrst), .bus_req(bus_req), .bus_wr(bus_wr),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata_q(bus_rdata_q),
    .bus_ack_q(bus_ack_q), .debug_halt_request(debug_halt_request),
    .port_pin_levels(port_pin_levels), .cmp_high(cmp_high), .mux_sel_q(mux_sel_q),
    .sample_q(sample_q), .trial_code_q(trial_code_q), .analog_pd_q(analog_pd_q));
  adc_afe_model i_adc_afe_model (.clk_sys(clk_sys), .mux_sel_q(mux_sel_q),
    .trial_code_q(trial_code_q), .analog_pd_q(analog_pd_q), .cmp_high(cmp_high));
  function automatic logic [15:0] lvl(input int ch);
    return 16'(10'h011 + 10'(ch) * 10'h07B);
  endfunction : lvl
  task automatic close_out();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    bus_req = 1'b1;
    bus_wr = wr;
    bus_addr = a;
    bus_wdata = d;
    @(negedge clk_sys);
    `CHK(bus_ack_q, 1'b1)
    rd = bus_rdata_q;
    bus_req = 1'b0;
  endtask : xfer
  task automatic rdchk(input logic [5:0] a, input logic [15:0] e);
    xfer(1'b0, a, 16'h0000);
    `CHK(rd, e)
  endtask : rdchk
  task automatic wait_done();
    for (int i = 0; i < 100; i++)
    begin
      repeat (20) @(negedge clk_sys);
      xfer(1'b0, ADC_OFS_STAT, 16'h0000);
      if (rd[15] === 1'b1)
        break;
    end
    `CHK(rd[15], 1'b1)
  endtask : wait_done
  task automatic t_regs();
    `CHK(analog_pd_q, 1'b1)
    rdchk(ADC_OFS_CFG, 16'h8080);
    rdchk(ADC_OFS_CLK, 16'h0003);
    rdchk(ADC_OFS_STAT, 16'h0000);
    rdchk(6'h02, 16'h0000);
    xfer(1'b1, ADC_OFS_CFG, 16'hFFFF);
    rdchk(ADC_OFS_CFG, 16'hE080);
    xfer(1'b1, ADC_OFS_CLK, 16'hFFFF);
    rdchk(ADC_OFS_CLK, 16'h00FF);
    xfer(1'b1, ADC_OFS_CHN, 16'hFFFF);
    rdchk(ADC_OFS_CHN, 16'h007F);
    `CHK(sample_q, 1'b0)
    xfer(1'b1, ADC_OFS_CFG, 16'h0000);
    rdchk(ADC_OFS_CFG, 16'h0000);
    repeat (200) @(negedge clk_sys);
  endtask : t_regs
  task automatic t_port();
    logic [7:0] pats [4] = '{8'h00, 8'hA5, 8'h5A, 8'hFF};
    xfer(1'b1, ADC_OFS_PORT, 16'hFFFF);
    foreach (pats[i])
    begin
      port_pin_levels = pats[i];
      rdchk(ADC_OFS_PORT, {8'h00, pats[i]});
    end
  endtask : t_port
  task automatic conv(input logic [15:0] c0, input logic [15:0] c1, input int n);
    int ch;
    xfer(1'b1, ADC_OFS_CLK, c0);
    xfer(1'b1, ADC_OFS_CHN, c1);
    wait_done();
    `CHK(rd & 16'h80FF, 16'h8000 | 16'((1 << n) - 1))
    for (int i = 0; i < n; i++)
    begin
      ch = c1[5] ? (c1[4] ? {c1[3], 3'(i)} : {c1[3:2], 2'(i)}) : c1[3:0];
      if (i == 0)
        `CHK(mux_sel_q, 4'(ch))
      rdchk(ADC_OFS_RES + 6'(2 * i), lvl(ch));
    end
    `CHK(trial_code_q, 10'(lvl(ch)))
  endtask : conv
  task automatic t_sample();
    int p;
    int cnt;
    for (int s = 0; s < 4; s++)
    begin
      p = 2 * (s + 3);
      xfer(1'b1, ADC_OFS_CLK, 16'h0080 | 16'(s << 5) | 16'(s + 2));
      xfer(1'b1, ADC_OFS_CHN, 16'h0000);
      cnt = 0;
      while (sample_q !== 1'b1 && cnt < 100)
      begin
        @(negedge clk_sys);
        cnt++;
      end
      cnt = 0;
      while (sample_q === 1'b1 && cnt < 2000)
      begin
        @(negedge clk_sys);
        cnt++;
      end
      `CHK(cnt > p * ((2 << s) - 1) && cnt <= p * (2 << s) + 1, 1'b1)
    end
  endtask : t_sample
  task automatic t_abort();
    int cnt;
    logic [15:0] st0;
    xfer(1'b1, ADC_OFS_CLK, 16'h0083);
    xfer(1'b1, ADC_OFS_CHN, 16'h0030);
    repeat (250) @(negedge clk_sys);
    xfer(1'b1, ADC_OFS_CHN, 16'h0030);
    rdchk(ADC_OFS_STAT, 16'h0000);
    repeat (250) @(negedge clk_sys);
    xfer(1'b1, ADC_OFS_CFG, 16'h8000);
    xfer(1'b0, ADC_OFS_STAT, 16'h0000);
    st0 = rd;
    `CHK(st0[15], 1'b0)
    repeat (1500) @(negedge clk_sys);
    `CHK(sample_q, 1'b0)
    `CHK(analog_pd_q, 1'b1)
    rdchk(ADC_OFS_STAT, st0);
    xfer(1'b1, ADC_OFS_CFG, 16'h0000);
    repeat (200) @(negedge clk_sys);
    xfer(1'b1, ADC_OFS_CLK, 16'h0003);
    xfer(1'b1, ADC_OFS_CHN, 16'h0001);
    wait_done();
    rdchk(ADC_OFS_RES, lvl(1) >> 2);
    xfer(1'b1, ADC_OFS_CLK, 16'h0083);
    xfer(1'b1, ADC_OFS_CHN, 16'h0041);
    wait_done();
    cnt = 0;
    while (sample_q !== 1'b1 && cnt < 300)
    begin
      @(negedge clk_sys);
      cnt++;
    end
    `CHK(cnt < 300, 1'b1)
  endtask : t_abort
  task automatic t_freeze();
    for (int f = 0; f < 4; f++)
    begin
      xfer(1'b1, ADC_OFS_CFG, 16'(f << 13));
      xfer(1'b1, ADC_OFS_CHN, 16'h0002);
      repeat (40) @(negedge clk_sys);
      debug_halt_request = 1'b1;
      repeat (1000) @(negedge clk_sys);
      xfer(1'b0, ADC_OFS_STAT, 16'h0000);
      `CHK(rd[15], ~1'(f >> 1))
      debug_halt_request = 1'b0;
      wait_done();
      rdchk(ADC_OFS_RES + 6'h06, lvl(2));
    end
  endtask : t_freeze
  initial
  begin
    forever #50 clk_sys = ~clk_sys;
  end
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    n_errors++;
    close_out();
  end
  initial
  begin
    repeat (20) @(negedge clk_sys);
    nrst = 1'b1;
    t_regs();
    t_port();
    conv(16'h0083, 16'h0005, 4);
    conv(16'h0083, 16'h0034, 8);
    conv(16'h00E2, 16'h0024, 4);
    t_sample();
    t_abort();
    t_freeze();
    close_out();
  end
endmodule : test_adc_ctrl
bind adc_ctrl adc_ctrl_sva #(.RES_W(RES_W)) i_adc_ctrl_sva (.clk_sys(clk_sys), .nrst(nrst),
  .bus_req(bus_req), .bus_wr(bus_wr), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_rdata_q(bus_rdata_q), .bus_ack_q(bus_ack_q), .debug_halt_request(debug_halt_request),
  .port_pin_levels(port_pin_levels), .cmp_high(cmp_high), .mux_sel_q(mux_sel_q),
  .sample_q(sample_q), .trial_code_q(trial_code_q), .analog_pd_q(analog_pd_q));
`default_nettype wire
